// ==== adcc3_defines.vh ====
`ifndef ADCC3_DEFINES_VH
`define ADCC3_DEFINES_VH

// Register word byte addresses
`define ADCC3_ADDR_CTRL3 8'h00
`define ADCC3_ADDR_CTRL2 8'h04
`define ADCC3_ADDR_STAT 8'h08
`define ADCC3_ADDR_MASK 8'h0C

// Control word three fields
`define ADCC3_SEL_HI 31
`define ADCC3_SEL_LO 30
`define ADCC3_DIV_HI 29
`define ADCC3_DIV_LO 24
`define ADCC3_SHARED_EN 23
`define ADCC3_DED_HI 20
`define ADCC3_DED_LO 16
`define ADCC3_UPD_RDY 10
`define ADCC3_MAN_MANUAL_SAMPLE_HOLD 9
`define ADCC3_CONV_REQ 8
`define ADCC3_GLB_TRIG 6

// Control word two field
`define ADCC3_SAMPLE_TIME_COUNT_HI 25
`define ADCC3_SAMPLE_TIME_COUNT_LO 16

// Clock source select codes
`define ADCC3_SRC_FRC 2'h3
`define ADCC3_SRC_REF3 2'h2
`define ADCC3_SRC_SYS 2'h1
`define ADCC3_SRC_PB3 2'h0

// Status and mask bits
`define ADCC3_EV_CONV 0
`define ADCC3_EV_TRIG 1
`define ADCC3_EV_DONE 2
`define ADCC3_EV_W 3

// Sequencer states
`define ADCC3_ST_IDLE 2'h0
`define ADCC3_ST_SAMPLE 2'h1
`define ADCC3_ST_CONV 2'h2

`define ADCC3_WORD_ZERO 32'h0000_0000

`endif

// ==== adcc3_ctrl.v ====
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`include "adcc3_defines.vh"

module adcc3_ctrl #(
	parameter DED_N = 5,
	parameter SAMPLE_TIME_COUNT_W = 10,
	parameter DIV_W = 6
) (
	input wire SYS_CLK,
	input wire RST_N,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output wire [31:0] WB_DAT_O,
	output wire WB_ACK_O,
	input wire SRC_FRC_TICK,
	input wire SRC_REF3_TICK,
	input wire SRC_SYS_TICK,
	input wire SRC_PB3_TICK,
	input wire HW_TRIGGER,
	input wire CONV_DONE,
	output reg [1:0] CLK_SRC_SEL,
	output reg CTRL_CLK_TICK,
	output reg SHARED_DIG_EN,
	output reg [DED_N-1:0] DED_DIG_EN,
	output reg SAMPLE_CLASS23,
	output reg SAMPLE_CLASS1,
	output reg CONV_START,
	output reg GLOBAL_TRIG_OUT,
	output wire IRQ
);

	reg ack_q;
	reg [31:0] rdat_q;
	reg [1:0] src_sel_q;
	reg [DIV_W-1:0] div_q;
	reg shared_en_q;
	reg [DED_N-1:0] ded_en_q;
	reg man_manual_sample_hold_q;
	reg conv_req_q;
	reg glb_trig_q;
	reg upd_rdy_q;
	reg [SAMPLE_TIME_COUNT_W-1:0] sample_time_count_q;
	reg [`ADCC3_EV_W-1:0] stat_q;
	reg [`ADCC3_EV_W-1:0] mask_q;
	reg [DIV_W-1:0] div_cnt_q;
	reg [SAMPLE_TIME_COUNT_W:0] manual_sample_hold_cnt_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg man_used_q;
	reg src_tick;
	reg [31:0] ctrl3_view;
	reg [31:0] rd_mux;
	wire req_take;
	wire wr_stb;
	wire rd_stb;
	wire [31:0] wmask;
	wire [31:0] ctrl3_w;
	wire [31:0] ctrl2_w;
	wire start_conv;
	wire [`ADCC3_EV_W-1:0] ev;
	wire [31:0] ctrl2_view;
	wire wr_ctrl3;
	wire rd_stat;

	// Sequencer state codes
	localparam [1:0] ST_IDLE = `ADCC3_ST_IDLE;
	localparam [1:0] ST_SAMPLE = `ADCC3_ST_SAMPLE;
	localparam [1:0] ST_CONV = `ADCC3_ST_CONV;

	// One wait state: ack one cycle after the request, dropped next cycle
	assign req_take = WB_CYC_I & WB_STB_I & ~ack_q;
	assign wr_stb = req_take & WB_WE_I;
	assign rd_stb = req_take & ~WB_WE_I;
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;
	assign IRQ = |(stat_q & mask_q);

	assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
	assign ctrl3_w = (ctrl3_view & ~wmask) | (WB_DAT_I & wmask);
	assign ctrl2_view = {{(32-SAMPLE_TIME_COUNT_W-`ADCC3_SAMPLE_TIME_COUNT_LO){1'b0}}, sample_time_count_q, {`ADCC3_SAMPLE_TIME_COUNT_LO{1'b0}}};
	assign ctrl2_w = (ctrl2_view & ~wmask) | (WB_DAT_I & wmask);
	assign wr_ctrl3 = wr_stb && (WB_ADR_I == `ADCC3_ADDR_CTRL3);
	assign rd_stat = rd_stb && (WB_ADR_I == `ADCC3_ADDR_STAT);

	always @* begin
		// Unimplemented bits, 22 and 21 among them, read zero
		ctrl3_view = `ADCC3_WORD_ZERO;
		ctrl3_view[`ADCC3_SEL_HI:`ADCC3_SEL_LO] = src_sel_q;
		ctrl3_view[`ADCC3_DIV_HI:`ADCC3_DIV_LO] = div_q;
		ctrl3_view[`ADCC3_SHARED_EN] = shared_en_q;
		ctrl3_view[`ADCC3_DED_HI:`ADCC3_DED_LO] = ded_en_q;
		ctrl3_view[`ADCC3_UPD_RDY] = upd_rdy_q;
		ctrl3_view[`ADCC3_MAN_MANUAL_SAMPLE_HOLD] = man_manual_sample_hold_q;
		ctrl3_view[`ADCC3_CONV_REQ] = conv_req_q;
		ctrl3_view[`ADCC3_GLB_TRIG] = glb_trig_q;
	end

	always @* begin
		case (WB_ADR_I)
			`ADCC3_ADDR_CTRL3: rd_mux = ctrl3_view;
			`ADCC3_ADDR_CTRL2: rd_mux = ctrl2_view;
			`ADCC3_ADDR_STAT: rd_mux = {{(32-`ADCC3_EV_W){1'b0}}, stat_q};
			`ADCC3_ADDR_MASK: rd_mux = {{(32-`ADCC3_EV_W){1'b0}}, mask_q};
			default: rd_mux = `ADCC3_WORD_ZERO;
		endcase
	end

	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ack_q <= 1'b0;
			rdat_q <= `ADCC3_WORD_ZERO;
		end else begin
			ack_q <= req_take;
			// Read data captured at the taking edge, held until the next read
			if (rd_stb)
				rdat_q <= rd_mux;
		end
	end

	// Software-owned configuration
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			src_sel_q <= `ADCC3_SRC_PB3;
			div_q <= {DIV_W{1'b0}};
			shared_en_q <= 1'b0;
			ded_en_q <= {DED_N{1'b0}};
			man_manual_sample_hold_q <= 1'b0;
			sample_time_count_q <= {SAMPLE_TIME_COUNT_W{1'b0}};
			mask_q <= {`ADCC3_EV_W{1'b0}};
		end else if (wr_stb) begin
			case (WB_ADR_I)
				`ADCC3_ADDR_CTRL3: begin
					src_sel_q <= ctrl3_w[`ADCC3_SEL_HI:`ADCC3_SEL_LO];
					div_q <= ctrl3_w[`ADCC3_DIV_HI:`ADCC3_DIV_LO];
					shared_en_q <= ctrl3_w[`ADCC3_SHARED_EN];
					ded_en_q <= ctrl3_w[`ADCC3_DED_HI:`ADCC3_DED_LO];
					man_manual_sample_hold_q <= ctrl3_w[`ADCC3_MAN_MANUAL_SAMPLE_HOLD];
				end
				`ADCC3_ADDR_CTRL2: sample_time_count_q <= ctrl2_w[`ADCC3_SAMPLE_TIME_COUNT_HI:`ADCC3_SAMPLE_TIME_COUNT_LO];
				`ADCC3_ADDR_MASK: begin
					// Mask bits sit in byte 0 only
					if (WB_SEL_I[0])
						mask_q <= WB_DAT_I[`ADCC3_EV_W-1:0];
				end
				default: ;
			endcase
		end
	end

	always @* begin
		case (src_sel_q)
			`ADCC3_SRC_FRC: src_tick = SRC_FRC_TICK;
			`ADCC3_SRC_REF3: src_tick = SRC_REF3_TICK;
			`ADCC3_SRC_SYS: src_tick = SRC_SYS_TICK;
			default: src_tick = SRC_PB3_TICK;
		endcase
	end

	// Divider restarts its count on the (div+1)th source tick
	// Lowering the field mid-count ends the period at once instead of wrapping
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			div_cnt_q <= {DIV_W{1'b0}};
			CTRL_CLK_TICK <= 1'b0;
		end else begin
			CTRL_CLK_TICK <= 1'b0;
			if (src_tick) begin
				if (div_cnt_q >= div_q) begin
					div_cnt_q <= {DIV_W{1'b0}};
					CTRL_CLK_TICK <= 1'b1;
				end else
					div_cnt_q <= div_cnt_q + 1'b1;
			end
		end
	end

	// Pending request held off while manual sampling is on
	assign start_conv = conv_req_q & ~man_manual_sample_hold_q & (state_q == ST_IDLE);

	// Sequencer: idle, timed or manual sample phase, one-cycle convert
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_conv)
					state_d = man_used_q ? ST_CONV : ST_SAMPLE;
				else if (HW_TRIGGER & ~man_manual_sample_hold_q)
					state_d = ST_SAMPLE;
			end
			ST_SAMPLE: begin
				// Manual bit holds the phase open; once used, the count no longer applies
				if (man_manual_sample_hold_q)
					state_d = ST_SAMPLE;
				else if (man_used_q)
					state_d = ST_CONV;
				else if (CTRL_CLK_TICK && manual_sample_hold_cnt_q[SAMPLE_TIME_COUNT_W-1:0] == sample_time_count_q)
					state_d = ST_CONV;
			end
			ST_CONV: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			manual_sample_hold_cnt_q <= {(SAMPLE_TIME_COUNT_W+1){1'b0}};
			man_used_q <= 1'b0;
			CONV_START <= 1'b0;
		end else begin
			state_q <= state_d;
			CONV_START <= (state_q == ST_CONV);
			if (state_q != ST_SAMPLE)
				manual_sample_hold_cnt_q <= {(SAMPLE_TIME_COUNT_W+1){1'b0}};
			else if (CTRL_CLK_TICK)
				manual_sample_hold_cnt_q <= manual_sample_hold_cnt_q + 1'b1;
			// Remember manual use until the conversion it stands in for
			if (man_manual_sample_hold_q)
				man_used_q <= 1'b1;
			else if (state_q == ST_CONV)
				man_used_q <= 1'b0;
		end
	end

	// Hardware-cleared request, trigger and update flags; write-set wins, and for the update flag done-set wins
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			conv_req_q <= 1'b0;
			glb_trig_q <= 1'b0;
			upd_rdy_q <= 1'b0;
			GLOBAL_TRIG_OUT <= 1'b0;
		end else begin
			GLOBAL_TRIG_OUT <= glb_trig_q;
			if (wr_ctrl3 && ctrl3_w[`ADCC3_CONV_REQ])
				conv_req_q <= 1'b1;
			else if (start_conv)
				conv_req_q <= 1'b0;
			// Trigger lives one cycle: cleared the cycle after it is set
			if (wr_ctrl3 && ctrl3_w[`ADCC3_GLB_TRIG])
				glb_trig_q <= 1'b1;
			else if (glb_trig_q)
				glb_trig_q <= 1'b0;
			// Done beats the clear of a conversion starting in the same cycle
			if (CONV_DONE)
				upd_rdy_q <= 1'b1;
			else if (state_q == ST_CONV)
				upd_rdy_q <= 1'b0;
		end
	end

	assign ev[`ADCC3_EV_CONV] = (state_q == ST_CONV);
	assign ev[`ADCC3_EV_TRIG] = glb_trig_q;
	assign ev[`ADCC3_EV_DONE] = CONV_DONE;

	genvar gi;
	generate
		for (gi = 0; gi < `ADCC3_EV_W; gi = gi + 1) begin : g_stat
			// Event wins over the read clear so no event is lost
			always @(posedge SYS_CLK) begin
				if (!RST_N)
					stat_q[gi] <= 1'b0;
				else if (ev[gi])
					stat_q[gi] <= 1'b1;
				else if (rd_stat)
					stat_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// Registered copies keep the analog-facing controls glitch free
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			CLK_SRC_SEL <= `ADCC3_SRC_PB3;
			SHARED_DIG_EN <= 1'b0;
			DED_DIG_EN <= {DED_N{1'b0}};
			SAMPLE_CLASS23 <= 1'b0;
			SAMPLE_CLASS1 <= 1'b0;
		end else begin
			CLK_SRC_SEL <= src_sel_q;
			SHARED_DIG_EN <= shared_en_q;
			DED_DIG_EN <= ded_en_q;
			SAMPLE_CLASS23 <= man_manual_sample_hold_q | (state_d == ST_SAMPLE);
			SAMPLE_CLASS1 <= (state_d == ST_SAMPLE);
		end
	end

endmodule

// ==== adcc3_chk.sv ====
module adcc3_chk (
	input wire SYS_CLK,
	input wire RST_N,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	input wire WB_ACK_O,
	input wire [1:0] CLK_SRC_SEL,
	input wire SHARED_DIG_EN,
	input wire SAMPLE_CLASS23,
	input wire SAMPLE_CLASS1,
	input wire CONV_START,
	input wire GLOBAL_TRIG_OUT
);
	timeunit 1ns / 1ps;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// Write to word three, seen at its ack edge
	sequence s_wr(b);
		WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00 && WB_SEL_I[b];
	endsequence
	property p_ack;
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
	endproperty
	a_ack: assert property (p_ack) else $error("late ack");
	property p_ak1;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ak1: assert property (p_ak1) else $error("long ack");
	property p_sel;
		s_wr(3) |=> CLK_SRC_SEL == $past(WB_DAT_I[31:30]);
	endproperty
	a_sel: assert property (p_sel) else $error("bad select");
	property p_sh;
		s_wr(2) |=> SHARED_DIG_EN == $past(WB_DAT_I[23]);
	endproperty
	a_sh: assert property (p_sh) else $error("bad shared enable");
	property p_man;
		s_wr(1) ##0 WB_DAT_I[9] |-> ##[1:2] SAMPLE_CLASS23;
	endproperty
	a_man: assert property (p_man) else $error("manual not sampling");
	property p_cls;
		SAMPLE_CLASS1 |-> SAMPLE_CLASS23;
	endproperty
	a_cls: assert property (p_cls) else $error("class split");
	property p_gt;
		GLOBAL_TRIG_OUT |=> !GLOBAL_TRIG_OUT;
	endproperty
	a_gt: assert property (p_gt) else $error("trigger stuck");
	property p_cs;
		CONV_START |=> !CONV_START;
	endproperty
	a_cs: assert property (p_cs) else $error("start stuck");
endmodule
bind adcc3_ctrl adcc3_chk chk_u (.*);

// ==== adcc3_conv_model.sv ====
module adcc3_conv_model (
	input wire clk,
	input wire start,
	input wire [3:0] lat,
	output logic done
);
	timeunit 1ns / 1ps;
	// Busy time from lat, so the bench picks fast or slow
	logic [4:0] n = 5'h00;
	initial done = 1'b0;
	always @(posedge clk) begin
		done <= n == 5'h01;
		n <= start ? {1'b0, lat} + 5'h01 : n - {4'h0, n != 5'h00};
	end
endmodule

// ==== adcc3_tb_top.sv ====
module adcc3_tb_top;
	timeunit 1ns / 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic hw = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [3:0] tr = 4'h1, lat = 4'h8;
	wire [31:0] dat;
	wire [1:0] csel;
	wire [4:0] ded;
	wire ack, done, cck, shen, s23, s1, cst, gto, irq;
	wire [4:0] ev = {done, s1, cst, gto, cck};
	int num_errors = 0, comparisons = 0, n, m;
	logic [31:0] rows [4][2] = '{'{32'hFFFF_0000, 32'hFF9F_0000},
		'{32'h8000_0400, 32'h8000_0000}, '{32'h4380_0000, 32'h4380_0000},
		'{32'h0018_0000, 32'h0018_0000}};
	always #4 clk = ~clk;
	always @(posedge clk) tr <= {tr[2:0], tr[3]};
	adcc3_ctrl dut_u (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(dat),
		.WB_ACK_O(ack), .SRC_FRC_TICK(tr[0]), .SRC_REF3_TICK(tr[1]), .SRC_SYS_TICK(1'b1),
		.SRC_PB3_TICK(tr[2]), .HW_TRIGGER(hw), .CONV_DONE(done), .CLK_SRC_SEL(csel),
		.CTRL_CLK_TICK(cck), .SHARED_DIG_EN(shen), .DED_DIG_EN(ded), .SAMPLE_CLASS23(s23),
		.SAMPLE_CLASS1(s1), .CONV_START(cst), .GLOBAL_TRIG_OUT(gto), .IRQ(irq));
	adcc3_conv_model conv_u (.clk(clk), .start(cst), .lat(lat), .done(done));
	task automatic test_done;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task automatic lost;
		num_errors++;
		test_done;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
			lost;
		rd = dat;
		cyc <= 1'b0;
	endtask
	task automatic wt(input int k);
		for (n = 0; n < 60 && ev[k] !== 1'b1; n++)
			@(posedge clk);
		if (ev[k] !== 1'b1)
			lost;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		foreach (rows[i]) begin
			bus(1'b1, 8'h00, rows[i][0]);
			bus(1'b0, 8'h00, 32'h0);
			chk(rd, rows[i][1]);
			chk({30'h0, csel}, {30'h0, rows[i][1][31:30]});
			chk({31'h0, shen}, {31'h0, rows[i][1][23]});
			chk({27'h0, ded}, {27'h0, rows[i][1][20:16]});
		end
		bus(1'b1, 8'h00, 32'h4300_0000);
		wt(0);
		@(posedge clk);
		wt(0);
		m = 0;
		do begin
			@(posedge clk);
			m++;
		end while (cck !== 1'b1 && m < 70);
		chk(m, 32'h4);
		bus(1'b1, 8'h0C, 32'h0);
		bus(1'b1, 8'h00, 32'h4300_0040);
		wt(1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, 8'h00, 32'h0);
		chk(rd & 32'h40, 32'h0);
		bus(1'b1, 8'h0C, 32'h2);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h2);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h04, 32'h0002_0000);
		bus(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0002_0000);
		bus(1'b1, 8'h00, 32'h4300_0200);
		repeat (2) @(posedge clk);
		chk({31'h0, s23}, 32'h1);
		chk({31'h0, s1}, 32'h0);
		bus(1'b1, 8'h00, 32'h4300_0000);
		bus(1'b1, 8'h00, 32'h4300_0100);
		m = 0;
		for (n = 0; n < 60 && cst !== 1'b1; n++) begin
			m |= s1;
			@(posedge clk);
		end
		chk(m, 32'h0);
		chk({31'h0, cst}, 32'h1);
		wt(4);
		repeat (2) @(posedge clk);
		bus(1'b0, 8'h00, 32'h0);
		chk(rd & 32'h400, 32'h400);
		lat <= 4'h1;
		hw <= 1'b1;
		@(posedge clk);
		hw <= 1'b0;
		wt(3);
		chk({31'h0, s23}, 32'h1);
		m = 0;
		for (n = 0; n < 60 && s1 === 1'b1; n++) begin
			m += cck;
			@(posedge clk);
		end
		chk(m, 32'h3);
		wt(2);
		wt(4);
		bus(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h5);
		hw <= 1'b1;
		@(posedge clk);
		hw <= 1'b0;
		wt(3);
		bus(1'b1, 8'h00, 32'h4300_0200);
		m = 0;
		for (n = 0; n < 40; n++) begin
			m |= cst;
			@(posedge clk);
		end
		chk(m, 32'h0);
		chk({31'h0, s23}, 32'h1);
		bus(1'b1, 8'h00, 32'h4300_0000);
		wt(2);
		test_done;
	end
endmodule
